// file: rtl/dac_load_pkg.sv
// package for the serial converter load interface
// assumes: shared by the shift stage and the top-level device module
package dac_load_pkg;
  // ==========================================================
  // widths
  localparam int unsigned code_width = 12;
  localparam int unsigned sync_stages = 2;

  // ==========================================================
  // reset values
  localparam logic [code_width-1:0] code_reset = 12'h000;

  // ==========================================================
  // timing figures, maximum output delay in ns, system clock in MHz
  localparam int unsigned sys_clk_mhz = 100;
  localparam int unsigned dout_delay_max_ns = 150;
  localparam int unsigned dout_delay_cycles =
    (dout_delay_max_ns * sys_clk_mhz) / 1000;

  // ==========================================================
  // output code bundle handed to the analog side
  typedef struct packed {
    logic [code_width-1:0] code;
    logic transparent;
  } dac_state_s;
endpackage : dac_load_pkg

// file: rtl/dac_shift_stage.sv
// serial shift register clocked by the link clock
// assumes: sclk is the host's serial clock; stage runs only on its edges
`timescale 1ns/100ps
`default_nettype none
module dac_shift_stage #(
  parameter int unsigned width = dac_load_pkg::code_width
) (
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic sdi,
  output logic [width-1:0] shift_q,
  output logic sdo
);
  if (width < 2) begin : g_bad_width
    $error("shift width must be at least two");
  end

  // ==========================================================
  // shift, msb enters first and leaves from the top stage
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[width-2:0], sdi}; // R1 R6
    end
  end

  // serial output is the final stage itself
  assign sdo = shift_q[width-1]; // R4 R7
endmodule : dac_shift_stage
`default_nettype wire

// file: rtl/serial_dac_load_interface.sv
// device-side serial load logic of a voltage-output converter
// assumes: host drives sclk, sdi and load_n; code feeds analog side on clk
//
// Overview of operation
// R1: rising serial clock shifts data input in
// R2: load low copies shift register to holding
// R3: holding follows shift register while load low
// R4: final stage appears on serial output
// R5: chained devices link output to next input
// R6: msb first, lsb last
// R7: shift and holding registers twelve bits
// R8: load high latches and keeps holding value
// R9: host shifts whole chain, then pulses load
`timescale 1ns/100ps
`default_nettype none
module serial_dac_load_interface #(
  parameter int unsigned width = dac_load_pkg::code_width
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic load_n,
  output logic sdo,
  output var dac_load_pkg::dac_state_s dac_state
);
  // ==========================================================
  // elaboration checks: the holding register and the code bundle
  // must agree, and the strobe needs a real two-stage synchroniser
  localparam int unsigned sync_depth = dac_load_pkg::sync_stages;
  localparam int unsigned last_stage = sync_depth - 1;

  if (width != dac_load_pkg::code_width) begin : g_bad_width
    $error("holding register width must match the code width");
  end

  if (sync_depth < 2) begin : g_bad_depth
    $error("strobe synchroniser needs at least two stages");
  end

  // ==========================================================
  // helper: two samples of the shifted word agree
  function automatic logic words_agree(
    input logic [width-1:0] a,
    input logic [width-1:0] b
  );
    return (a == b);
  endfunction : words_agree

  // ==========================================================
  // link domain: shift register on the serial clock
  logic [width-1:0] shift_q;

  dac_shift_stage #(
    .width(width)
  ) u_shift (
    .sclk(sclk),
    .rst_n(rst_n),
    .sdi(sdi),
    .shift_q(shift_q),
    .sdo(sdo)
  );

  // ==========================================================
  // system domain: strobe synchroniser, one flop per stage
  // load_n is a free-running pin, so no logic reads it before two flops
  logic load_sync_q [sync_depth];
  logic load_late_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_sync_q[0] <= 1'b0;
    end else begin
      load_sync_q[0] <= ~load_n;
    end
  end

  for (genvar i = 1; i < sync_depth; i++) begin : g_load_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        load_sync_q[i] <= 1'b0;
      end else begin
        load_sync_q[i] <= load_sync_q[i-1];
      end
    end
  end

  // one extra stage so the strobe lines up with the word filter below;
  // without it a strobe rising just after the last shift could close
  // the holding register before the final word has crossed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_late_q <= 1'b0;
    end else begin
      load_late_q <= load_sync_q[last_stage];
    end
  end

  // ==========================================================
  // system domain: shifted word crossing
  // the word runs through the same number of stages and is taken only
  // when two later samples agree; a sample caught mid-shift differs
  // from its neighbour and is dropped, at the price of some latency.
  // limitation: the link must hold each word for three clk cycles
  logic [width-1:0] code_sync_q [sync_depth];
  logic [width-1:0] code_late_q;
  logic [width-1:0] shift_c_q;
  logic code_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_sync_q[0] <= dac_load_pkg::code_reset;
    end else begin
      code_sync_q[0] <= shift_q;
    end
  end

  for (genvar i = 1; i < sync_depth; i++) begin : g_code_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        code_sync_q[i] <= dac_load_pkg::code_reset;
      end else begin
        code_sync_q[i] <= code_sync_q[i-1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_late_q <= dac_load_pkg::code_reset;
    end else begin
      code_late_q <= code_sync_q[last_stage];
    end
  end

  assign code_ok = words_agree(code_late_q, code_sync_q[last_stage]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_c_q <= dac_load_pkg::code_reset;
    end else if (code_ok) begin
      shift_c_q <= code_late_q;
    end
  end

  // ==========================================================
  // holding register state: latched or open (transparent)
  typedef enum logic [1:0] {
    st_latched = 2'h1,
    st_open = 2'h2
  } hold_state_e;

  hold_state_e state_q;
  hold_state_e state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_latched: begin
        if (load_late_q) begin
          state_d = st_open; // R2
        end
      end
      st_open: begin
        if (!load_late_q) begin
          state_d = st_latched; // R8
        end
      end
      default: begin
        state_d = st_latched;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_latched;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // holding register: follows the crossed word while open, and is
  // left alone while latched, so shifting under a high strobe never
  // reaches the converter code
  logic [width-1:0] hold_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= dac_load_pkg::code_reset;
    end else if (state_q == st_open) begin
      hold_q <= shift_c_q; // R2 R3
    end
  end

  // transparency flag, registered alongside the state
  logic transparent_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transparent_q <= 1'b0;
    end else begin
      transparent_q <= (state_d == st_open); // R3 R8
    end
  end

  // ==========================================================
  // outputs
  assign dac_state = '{code: hold_q, transparent: transparent_q}; // R7
endmodule : serial_dac_load_interface
`default_nettype wire

// file: verification/dac_load_sva.sv
// checker for the serial load interface, top ports only
// assumes: bound to each instance from tb_top
`timescale 1ns/100ps
`default_nettype none
module dac_load_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic load_n,
  input wire logic sdo,
  input wire dac_load_pkg::dac_state_s dac_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // strobe, holding code and serial output
  chk_load_on: assert property ($fell(load_n) |-> ##[1:6]
    dac_state.transparent) else $error("flag late");
  chk_load_off: assert property ($rose(load_n) |-> ##[1:6]
    !dac_state.transparent) else $error("flag stuck");
  chk_flag_low: assert property (!load_n[*6] |->
    dac_state.transparent) else $error("flag low");
  chk_flag_high: assert property (load_n[*6] |->
    !dac_state.transparent) else $error("flag high");
  chk_code_hold: assert property (load_n[*6] |=>
    $stable(dac_state.code)) else $error("code moved");
  chk_top_follow: assert property ((!load_n && $stable(sdo))[*8]
    |-> dac_state.code[11] == sdo) else $error("code top");
  chk_sdo_edge: assert property ($changed(sdo) |-> sclk)
    else $error("sdo moved");
  cover property ($fell(load_n));
  cover property (!load_n ##1 $changed(dac_state.code));
  cover property (load_n[*6] ##1 $changed(sdo));
endmodule : dac_load_sva
`default_nettype wire

// file: verification/host_model.sv
// host controller: serial clock, data and strobe
// assumes: clock stands low between frames
`timescale 1ns/100ps
`default_nettype none
module host_model (
  output var logic sclk,
  output var logic sdi,
  output var logic load_n
);
  initial begin
    sclk = 0;
    sdi = 0;
    load_n = 1;
  end
  // msb first; skew shifts the frame's phase against clk, period 30 ns
  task automatic send(input logic [11:0] w, input int skew);
    #(skew);
    for (int i = 11; i >= 0; i--) begin
      sdi = w[i];
      #15 sclk = 1;
      #15 sclk = 0;
    end
    sdi = ~sdi;
  endtask : send
  task automatic level(input logic v);
    load_n = v;
    #150;
  endtask : level
endmodule : host_model
`default_nettype wire

// file: verification/tb_top.sv
// two chained devices driven by the host model
// assumes: design package compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst_n, mid, sdo;
  logic sclk, sdi, load_n;
  logic [11:0] w0, w1, ex;
  dac_load_pkg::dac_state_s sa, sb;
  int n_fail = 0, cmp_count = 0, seed = 65332, cyc = 0;
  host_model i_host_model(.sclk(sclk), .sdi(sdi), .load_n(load_n));
  serial_dac_load_interface i_serial_dac_load_interface(.clk(clk),
    .rst_n(rst_n), .sclk(sclk), .sdi(sdi), .load_n(load_n),
    .sdo(mid), .dac_state(sa));
  serial_dac_load_interface i_serial_dac_load_interface_b(.clk(clk),
    .rst_n(rst_n), .sclk(sclk), .sdi(mid), .load_n(load_n),
    .sdo(sdo), .dac_state(sb));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (++cyc == 30000) begin
    n_fail++;
    give_verdict;
  end
  initial begin
    rst_n = 0;
    ex = 12'h000;
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    chk(sa.code, 12'h000);
    for (int k = 0; k < 6; k++) begin
      w0 = (k == 0) ? 12'hfff : 12'($random(seed));
      w1 = (k == 1) ? 12'h000 : 12'($random(seed));
      @(posedge clk) #1;
      i_host_model.send(w0, k * 3);
      i_host_model.send(w1, 0);
      chk(sa.code, ex);
      chk_bit(sdo, w0[11]);
      i_host_model.level(0);
      chk_bit(sa.transparent, 1'b1);
      i_host_model.level(1);
      chk_bit(sb.transparent, 1'b0);
      chk(sa.code, w1);
      chk(sb.code, w0);
      i_host_model.level(0);
      i_host_model.send(w0, 0);
      i_host_model.level(1);
      chk(sa.code, w0);
      chk(sb.code, w1);
      ex = w0;
      $display("test %0d done", k);
    end
    give_verdict;
  end
endmodule : tb_top
bind serial_dac_load_interface dac_load_sva i_dac_load_sva(.clk(clk),
  .rst_n(rst_n), .sclk(sclk), .load_n(load_n), .sdo(sdo),
  .dac_state(dac_state));
`default_nettype wire
